// [core/fcr_config_regs.sv]
// Configuration register bank of a serial flash, reached over the flash link.
`timescale 1ns/1ps
// Functional notes
// - New setting acts only after its write
// - Drive strength code bits 2:0, default 111
// - One-time protect origin bit 3: top/bottom
// - Primary bits change only through write-status
// - Preamble enable bit 4 drives dummy pattern
// - Mode field: SPI, single, double; 11 inhibited
// - Strobe in single rate, lead cycle bits
// - Three-bit wait cycle field, default 000
// - Flag pin low per chosen ECC condition
// - Check chunk size 16 to 128 bytes
// - Check pin drives only when enabled
// - Bit 0 picks one of two preambles
// - Read-only fail address valid flag bit 7
// - Fail state: corrected, double, double program
// - Four-bit fail counter, separate per half
// - Wait codes map 20 down to 6 cycles
// - Preamble patterns per data line and select
// - Counter saturates at 15, counts repeats
// - Writing 00 clears ECC status
module fcr_config_regs
    import fcr_pkg::*;
#(
    parameter logic ORIGIN_DEFAULT = 1'b0
)(
    // System clock and reset
    input  wire logic        clk,
    input  wire logic        rst_n,
    // Flash link pins
    input  wire logic        linkClk,
    input  wire logic        csN,
    input  wire logic        si,
    output logic             so,
    output logic             soEn,
    // ECC events from the array read path
    input  wire logic        eccChunkFail,
    input  wire logic        eccSingleFix,
    input  wire logic        eccDoubleErr,
    input  wire logic        eccDoubleProg,
    input  wire logic        eccUpperHalf,
    // Configuration toward the device
    output logic [2:0]       driveStrength,
    output logic             protectOrigin,
    output logic             preambleEnable,
    output logic             singleRateOctalEn,
    output logic             doubleRateOctalEn,
    output logic             strobeInSingleRate,
    output logic             strobeLeadCycle,
    output logic [4:0]       waitCycles,
    output logic [7:0]       chunkBytes,
    output logic             checkPinOutEn,
    output logic [15:0]      preamblePattern,
    output logic [15:0]      preambleLine3,
    output logic             eccFlagPinN
);

    // Link side results.
    logic        linkFrame;
    logic        linkWr;
    logic        linkRd;
    logic [7:0]  linkOp;
    logic [31:0] linkAddr;
    logic [7:0]  linkData;

    // Registers.
    logic [7:0]  primary_ff;
    logic [7:0]  mode_ff;
    logic [7:0]  strobe_ff;
    logic [7:0]  wait_ff;
    logic [7:0]  eccPin_ff;
    logic [7:0]  check_ff;
    logic [7:0]  eccStat_ff [2];
    logic [7:0]  rdData_ff;
    logic [1:0]  activeMode_ff;

    // Crossing of link levels: bit 0 frame, bit 1 write, bit 2 read.
    logic [2:0]  sync1_ff;
    logic [2:0]  sync2_ff;
    logic [2:0]  prev_ff;

    // Registered outputs.
    logic [2:0]  driveStrength_ff;
    logic        protectOrigin_ff;
    logic        preambleEnable_ff;
    logic        singleRate_ff;
    logic        doubleRate_ff;
    logic        strobeSgl_ff;
    logic        strobeLead_ff;
    logic [4:0]  waitCycles_ff;
    logic [7:0]  chunkBytes_ff;
    logic        checkOut_ff;
    logic [15:0] patMain_ff;
    logic [15:0] patLine3_ff;
    logic        eccFlagPinN_ff;

    fcr_link_port u_link (
        .linkClk     (linkClk),
        .csN         (csN),
        .si          (si),
        .so          (so),
        .soEn        (soEn),
        .frameActive (linkFrame),
        .wrValid     (linkWr),
        .rdReq       (linkRd),
        .cmdOp       (linkOp),
        .cmdAddr     (linkAddr),
        .cmdData     (linkData),
        .rdData      (rdData_ff)
    );

    // Edges are taken after the second flop only.
    wire logic frameStart = sync2_ff[0] & ~prev_ff[0];
    wire logic wrTake     = sync2_ff[1] & ~prev_ff[1];
    wire logic rdTake     = sync2_ff[2] & ~prev_ff[2];

    // Write decode. The link holds the fields stable from the write level until the next frame.
    wire logic       wrStatus  = wrTake && (linkOp == CMD_WRITE_STATUS);
    wire logic       wrCfg2    = wrTake && (linkOp == CMD_WRITE_CFG2);
    wire logic       hitMode   = wrCfg2 && (linkAddr == ADDR_MODE);
    wire logic       hitStrobe = wrCfg2 && (linkAddr == ADDR_STROBE);
    wire logic       hitWait   = wrCfg2 && (linkAddr == ADDR_WAIT);
    wire logic       hitEccPin = wrCfg2 && (linkAddr == ADDR_ECC_PIN);
    wire logic       hitCheck  = wrCfg2 && (linkAddr == ADDR_CHECK);
    wire logic       isEccAddr = (linkAddr[25:0] == ADDR_ECC_STAT)
                                 && (linkAddr[31:27] == 5'h00);
    wire logic       eccClrHit = wrCfg2 && isEccAddr && (linkData == ECC_CLEAR_DATA);
    wire logic       modeLegal = (linkData[1:0] != MODE_INHIBIT);

    // Reserved bits stay at their default because only masked bits are ever loaded.
    wire logic [7:0] primaryWr = (linkData & MASK_PRIMARY)
                                 | {3'h0, 1'b0, primary_ff[POS_ORIGIN], 3'h0};
    wire logic [7:0] nxt_primary = wrStatus ? primaryWr : primary_ff;

    // Read decode.
    wire logic       rdCfg2 = (linkOp == CMD_READ_CFG2);
    wire logic [7:0] cfg2Read =
        (linkAddr == ADDR_MODE)    ? mode_ff   :
        (linkAddr == ADDR_STROBE)  ? strobe_ff :
        (linkAddr == ADDR_WAIT)    ? wait_ff   :
        (linkAddr == ADDR_ECC_PIN) ? eccPin_ff :
        (linkAddr == ADDR_CHECK)   ? check_ff  :
        isEccAddr                  ? eccStat_ff[linkAddr[HALF_BIT]] : 8'h00;
    wire logic [7:0] nxt_rdData = rdTake ? (rdCfg2 ? cfg2Read : primary_ff) : rdData_ff;

    // ECC status per memory half; an event in the clearing cycle survives the clear.
    logic [7:0] nxt_eccStat [2];
    logic [1:0] halfFlag;
    genvar h;
    generate
        for (h = 0; h < 2; h++) begin : g_half
            wire logic       clrThis = eccClrHit && (linkAddr[HALF_BIT] == 1'(h));
            wire logic [7:0] base    = clrThis ? RST_ECC : eccStat_ff[h];
            wire logic       evThis  = eccChunkFail && (eccUpperHalf == 1'(h));
            wire logic [3:0] cntNext = (base[3:0] == COUNT_MAX) ? COUNT_MAX
                                       : base[3:0] + 4'h1;
            assign nxt_eccStat[h] = evThis ?
                {1'b1,
                 base[POS_DBL_PROG] | eccDoubleProg,
                 base[POS_DBL_ERR] | eccDoubleErr,
                 base[POS_SGL_FIX] | eccSingleFix,
                 cntNext} : base;
            wire logic dblProg = eccStat_ff[h][POS_DBL_PROG];
            wire logic dblErr  = eccStat_ff[h][POS_DBL_ERR];
            wire logic sglFix  = eccStat_ff[h][POS_SGL_FIX];
            assign halfFlag[h] =
                (eccPin_ff[1:0] == ECC_PIN_DBL_OR_PROG) ? (dblErr | dblProg) :
                (eccPin_ff[1:0] == ECC_PIN_ANY_OR_PROG) ? (dblErr | dblProg | sglFix) :
                (eccPin_ff[1:0] == ECC_PIN_DBL_ONLY)    ? dblErr :
                (dblErr | sglFix);
        end
    endgenerate

    // Decoded outputs.
    wire logic [4:0] nxt_waitCycles = WAIT_BASE - {1'b0, wait_ff[2:0], 1'b0};
    wire logic [7:0] nxt_chunkBytes = CHUNK_BASE << check_ff[POS_CHK_HI:POS_CHK_LO];
    wire logic       patSel         = check_ff[POS_PAT_SEL];
    wire logic [15:0] nxt_patMain   = patSel ? PAT_B : PAT_A_MAIN;
    wire logic [15:0] nxt_patLine3  = patSel ? PAT_B : PAT_A_LINE3;
    wire logic [1:0] nxt_activeMode = frameStart ? mode_ff[1:0] : activeMode_ff;

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            sync1_ff <= '0;
            sync2_ff <= '0;
            prev_ff  <= '0;
        end else begin
            sync1_ff <= {linkRd, linkWr, linkFrame};
            sync2_ff <= sync1_ff;
            prev_ff  <= sync2_ff;
        end
    end

    // Settings load only on a completed write; otherwise the old value stands.
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            primary_ff <= {3'h0, 1'b0, ORIGIN_DEFAULT, RST_DRIVE};
            mode_ff    <= RST_CFG2;
            strobe_ff  <= RST_CFG2;
            wait_ff    <= RST_CFG2;
            eccPin_ff  <= RST_CFG2;
            check_ff   <= RST_CFG2;
        end else begin
            primary_ff <= nxt_primary;
            if (hitMode && modeLegal) begin
                mode_ff <= linkData & MASK_MODE;
            end
            if (hitStrobe) begin
                strobe_ff <= linkData & MASK_STROBE;
            end
            if (hitWait) begin
                wait_ff <= linkData & MASK_WAIT;
            end
            if (hitEccPin) begin
                eccPin_ff <= linkData & MASK_ECC_PIN;
            end
            if (hitCheck) begin
                check_ff <= linkData & MASK_CHECK;
            end
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            eccStat_ff[0] <= RST_ECC;
            eccStat_ff[1] <= RST_ECC;
            rdData_ff     <= 8'h00;
            activeMode_ff <= MODE_SPI;
        end else begin
            eccStat_ff[0] <= nxt_eccStat[0];
            eccStat_ff[1] <= nxt_eccStat[1];
            rdData_ff     <= nxt_rdData;
            activeMode_ff <= nxt_activeMode;
        end
    end

    // The origin bit can only be raised; a write of 0 after a 1 has no effect.
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            driveStrength_ff  <= RST_DRIVE;
            protectOrigin_ff  <= ORIGIN_DEFAULT;
            preambleEnable_ff <= 1'b0;
            singleRate_ff     <= 1'b0;
            doubleRate_ff     <= 1'b0;
            strobeSgl_ff      <= 1'b0;
            strobeLead_ff     <= 1'b0;
            waitCycles_ff     <= WAIT_BASE;
            chunkBytes_ff     <= CHUNK_BASE;
            checkOut_ff       <= 1'b0;
            patMain_ff        <= PAT_A_MAIN;
            patLine3_ff       <= PAT_A_LINE3;
            eccFlagPinN_ff    <= 1'b1;
        end else begin
            driveStrength_ff  <= primary_ff[POS_DRIVE_HI:0];
            protectOrigin_ff  <= primary_ff[POS_ORIGIN];
            preambleEnable_ff <= primary_ff[POS_PREAMBLE];
            singleRate_ff     <= (activeMode_ff == MODE_SINGLE);
            doubleRate_ff     <= (activeMode_ff == MODE_DOUBLE);
            strobeSgl_ff      <= strobe_ff[POS_STROBE_SGL];
            strobeLead_ff     <= strobe_ff[POS_STROBE_LEAD];
            waitCycles_ff     <= nxt_waitCycles;
            chunkBytes_ff     <= nxt_chunkBytes;
            checkOut_ff       <= check_ff[POS_CHK_OUT];
            patMain_ff        <= nxt_patMain;
            patLine3_ff       <= nxt_patLine3;
            eccFlagPinN_ff    <= ~(|halfFlag);
        end
    end

    assign driveStrength      = driveStrength_ff;
    assign protectOrigin      = protectOrigin_ff;
    assign preambleEnable     = preambleEnable_ff;
    assign singleRateOctalEn  = singleRate_ff;
    assign doubleRateOctalEn  = doubleRate_ff;
    assign strobeInSingleRate = strobeSgl_ff;
    assign strobeLeadCycle    = strobeLead_ff;
    assign waitCycles         = waitCycles_ff;
    assign chunkBytes         = chunkBytes_ff;
    assign checkPinOutEn      = checkOut_ff;
    assign preamblePattern    = patMain_ff;
    assign preambleLine3      = patLine3_ff;
    assign eccFlagPinN        = eccFlagPinN_ff;

endmodule

// [core/fcr_link_port.sv]
// Serial link front end: frames commands, addresses and data on the link clock.
`timescale 1ns/1ps
module fcr_link_port
    import fcr_pkg::*;
(
    // Link pins
    input  wire logic        linkClk,
    input  wire logic        csN,
    input  wire logic        si,
    output logic             so,
    output logic             soEn,
    // Frame results toward the system clock side
    output logic             frameActive,
    output logic             wrValid,
    output logic             rdReq,
    output logic [7:0]       cmdOp,
    output logic [31:0]      cmdAddr,
    output logic [7:0]       cmdData,
    // Read data from the system clock side
    input  wire logic [7:0]  rdData
);

    logic [CNT_W-1:0] bitCnt_ff;
    logic [7:0]       shift_ff;
    logic [7:0]       op_ff;
    logic [31:0]      addr_ff;
    logic [7:0]       data_ff;
    logic             frame_ff;
    logic             wrValid_ff;
    logic             rdReq_ff;
    logic             so_ff;
    logic             soEn_ff;

    wire logic [7:0]       byteIn    = {shift_ff[6:0], si};
    wire logic             isCfg2    = (op_ff == CMD_WRITE_CFG2) || (op_ff == CMD_READ_CFG2);
    wire logic [CNT_W-1:0] outStart  = (op_ff == CMD_READ_CFG) ? OUT_START_CFG : OUT_START_CFG2;
    wire logic             isRead    = (op_ff == CMD_READ_CFG) || (op_ff == CMD_READ_CFG2);
    wire logic [CNT_W-1:0] outIdx    = bitCnt_ff - outStart;
    wire logic             outWindow = isRead && (bitCnt_ff >= outStart)
                                       && (bitCnt_ff < outStart + 7'h08);

    // Chip select high ends the frame; the link clock may be stopped between frames.
    always_ff @(posedge linkClk or posedge csN) begin
        if (csN) begin
            bitCnt_ff  <= '0;
            shift_ff   <= '0;
            frame_ff   <= 1'b0;
            wrValid_ff <= 1'b0;
            rdReq_ff   <= 1'b0;
        end else begin
            frame_ff <= 1'b1;
            shift_ff <= byteIn;
            if (bitCnt_ff != CNT_MAX) begin
                bitCnt_ff <= bitCnt_ff + 7'h01;
            end
            if (bitCnt_ff == BIT_OPCODE_END && byteIn == CMD_READ_CFG) begin
                rdReq_ff <= 1'b1;
            end
            if (bitCnt_ff == BIT_CFG_END && op_ff == CMD_WRITE_STATUS) begin
                wrValid_ff <= 1'b1;
            end
            if (bitCnt_ff == BIT_ADDR_END && op_ff == CMD_READ_CFG2) begin
                rdReq_ff <= 1'b1;
            end
            if (bitCnt_ff == BIT_DATA2_END && op_ff == CMD_WRITE_CFG2) begin
                wrValid_ff <= 1'b1;
            end
        end
    end

    // Command fields hold their value past the frame so the other side can take them.
    always_ff @(posedge linkClk) begin
        if (!csN) begin
            if (bitCnt_ff == BIT_OPCODE_END) begin
                op_ff <= byteIn;
            end
            if (isCfg2 && bitCnt_ff > BIT_OPCODE_END && bitCnt_ff <= BIT_ADDR_END) begin
                addr_ff <= {addr_ff[30:0], si};
            end
            if ((bitCnt_ff == BIT_CFG_END && op_ff == CMD_WRITE_STATUS)
                || (bitCnt_ff == BIT_DATA2_END && op_ff == CMD_WRITE_CFG2)) begin
                data_ff <= byteIn;
            end
        end
    end

    // Read data leaves on the falling edge so the host samples it on the next rising one.
    always_ff @(negedge linkClk or posedge csN) begin
        if (csN) begin
            so_ff   <= 1'b0;
            soEn_ff <= 1'b0;
        end else begin
            soEn_ff <= outWindow;
            so_ff   <= outWindow ? rdData[3'(7 - outIdx)] : 1'b0;
        end
    end

    assign so          = so_ff;
    assign soEn        = soEn_ff;
    assign frameActive = frame_ff;
    assign wrValid     = wrValid_ff;
    assign rdReq       = rdReq_ff;
    assign cmdOp       = op_ff;
    assign cmdAddr     = addr_ff;
    assign cmdData     = data_ff;

endmodule

// [shared/fcr_pkg.sv]
// Shared constants for the flash configuration register block.
package fcr_pkg;

    // Link command opcodes (single-bit serial framing).
    localparam logic [7:0] CMD_WRITE_STATUS = 8'h01;
    localparam logic [7:0] CMD_READ_CFG     = 8'h15;
    localparam logic [7:0] CMD_WRITE_CFG2   = 8'h72;
    localparam logic [7:0] CMD_READ_CFG2    = 8'h71;

    // Link frame bit positions, counted in link clock edges from chip select.
    localparam int         CNT_W          = 7;
    localparam logic [6:0] BIT_OPCODE_END = 7'h07;
    localparam logic [6:0] BIT_STATUS_END = 7'h0f;
    localparam logic [6:0] BIT_CFG_END    = 7'h17;
    localparam logic [6:0] BIT_ADDR_END   = 7'h27;
    localparam logic [6:0] BIT_DATA2_END  = 7'h2f;
    localparam logic [6:0] OUT_START_CFG  = 7'h10;
    localparam logic [6:0] OUT_START_CFG2 = 7'h30;
    localparam logic [6:0] CNT_MAX        = 7'h7f;

    // Second configuration space addresses.
    localparam logic [31:0] ADDR_MODE     = 32'h0000_0000;
    localparam logic [31:0] ADDR_STROBE   = 32'h0000_0200;
    localparam logic [31:0] ADDR_WAIT     = 32'h0000_0300;
    localparam logic [31:0] ADDR_ECC_PIN  = 32'h0000_0400;
    localparam logic [31:0] ADDR_CHECK    = 32'h0000_0500;
    localparam logic [25:0] ADDR_ECC_STAT = 26'h000_0800;
    localparam int          HALF_BIT      = 26;

    // Writable bit masks; bits outside a mask keep their reset value.
    localparam logic [7:0] MASK_PRIMARY = 8'h1f;
    localparam logic [7:0] MASK_MODE    = 8'h03;
    localparam logic [7:0] MASK_STROBE  = 8'h03;
    localparam logic [7:0] MASK_WAIT    = 8'h07;
    localparam logic [7:0] MASK_ECC_PIN = 8'h03;
    localparam logic [7:0] MASK_CHECK   = 8'h71;

    // Reset values.
    localparam logic [2:0] RST_DRIVE    = 3'h7;
    localparam logic [7:0] RST_CFG2     = 8'h00;
    localparam logic [7:0] RST_ECC      = 8'h00;
    localparam logic [7:0] ECC_CLEAR_DATA = 8'h00;

    // Field positions.
    localparam int POS_DRIVE_HI   = 2;
    localparam int POS_ORIGIN     = 3;
    localparam int POS_PREAMBLE   = 4;
    localparam int POS_STROBE_SGL = 1;
    localparam int POS_STROBE_LEAD = 0;
    localparam int POS_CHK_HI     = 6;
    localparam int POS_CHK_LO     = 5;
    localparam int POS_CHK_OUT    = 4;
    localparam int POS_PAT_SEL    = 0;
    localparam int POS_VALID      = 7;
    localparam int POS_DBL_PROG   = 6;
    localparam int POS_DBL_ERR    = 5;
    localparam int POS_SGL_FIX    = 4;

    // Interface mode codes.
    localparam logic [1:0] MODE_SPI     = 2'h0;
    localparam logic [1:0] MODE_SINGLE  = 2'h1;
    localparam logic [1:0] MODE_DOUBLE  = 2'h2;
    localparam logic [1:0] MODE_INHIBIT = 2'h3;

    // Flag pin condition codes.
    localparam logic [1:0] ECC_PIN_DBL_OR_PROG     = 2'h0;
    localparam logic [1:0] ECC_PIN_ANY_OR_PROG     = 2'h1;
    localparam logic [1:0] ECC_PIN_DBL_ONLY        = 2'h2;
    localparam logic [1:0] ECC_PIN_ANY             = 2'h3;

    // Wait cycle and chunk size decoding.
    localparam logic [4:0] WAIT_BASE  = 5'h14;
    localparam logic [7:0] CHUNK_BASE = 8'h10;
    localparam logic [3:0] COUNT_MAX  = 4'hf;

    // Preamble patterns, first bit in the top position.
    localparam logic [15:0] PAT_A_MAIN  = 16'h349a;
    localparam logic [15:0] PAT_A_LINE3 = 16'h3514;
    localparam logic [15:0] PAT_B       = 16'h5555;

endpackage

// [tb/fcr_config_monitor.sv]
// Checker for the configuration register outputs.
`timescale 1ns/1ps
module fcr_config_monitor (
    // Clock, reset and link select
    input wire logic        clk,
    input wire logic        rst_n,
    input wire logic        csN,
    // Error events
    input wire logic        eccChunkFail,
    input wire logic        eccDoubleErr,
    // Configuration outputs
    input wire logic [2:0]  driveStrength,
    input wire logic        protectOrigin,
    input wire logic        preambleEnable,
    input wire logic        singleRateOctalEn,
    input wire logic        doubleRateOctalEn,
    input wire logic [4:0]  waitCycles,
    input wire logic [7:0]  chunkBytes,
    input wire logic        checkPinOutEn,
    input wire logic [15:0] preamblePattern,
    input wire logic [15:0] preambleLine3,
    input wire logic        eccFlagPinN
);
    logic [4:0] idleCnt_ff;

    // Settings only move through a link frame, so a long idle link means no change.
    always_ff @(posedge clk) begin
        if (!rst_n || !csN) begin
            idleCnt_ff <= 5'h00;
        end else if (idleCnt_ff != 5'h1f) begin
            idleCnt_ff <= idleCnt_ff + 5'h01;
        end
    end

    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);

    wait_range_a: assert property (!waitCycles[0] && waitCycles >= 5'h06 && waitCycles <= 5'h14)
        else $error("wait cycle count outside table");
    chunk_size_a: assert property (chunkBytes inside {8'h10, 8'h20, 8'h40, 8'h80})
        else $error("chunk size not a legal value");
    pattern_pair_a: assert property ((preamblePattern == 16'h349a && preambleLine3 == 16'h3514)
        || (preamblePattern == 16'h5555 && preambleLine3 == 16'h5555)) else $error("bad preamble");
    mode_excl_a: assert property (!(singleRateOctalEn && doubleRateOctalEn))
        else $error("both octal modes active");
    origin_sticky_a: assert property ($past(rst_n) && $past(protectOrigin) |-> protectOrigin)
        else $error("protect origin returned to top");
    flag_cause_a: assert property ($fell(eccFlagPinN) |-> $past(eccChunkFail, 2))
        else $error("flag pin fell without an event");
    flag_double_a: assert property (eccChunkFail && eccDoubleErr |-> ##2 !eccFlagPinN)
        else $error("double error did not lower flag pin");
    idle_stable_a: assert property (idleCnt_ff >= 5'h14 |-> $stable({driveStrength,
        protectOrigin, preambleEnable, waitCycles, chunkBytes, checkPinOutEn}))
        else $error("setting changed with the link idle");

    cover property ($fell(eccFlagPinN));
    cover property (doubleRateOctalEn);
    cover property (chunkBytes == 8'h80);
    cover property ($rose(protectOrigin));
endmodule

bind fcr_config_regs fcr_config_monitor u_mon (.*);

// [tb/fcr_host_model.sv]
// Host controller model that drives the single-bit flash link.
`timescale 1ns/1ps
module fcr_host_model (
    // Link pins toward the device
    output logic linkClk,
    output logic csN,
    output logic si,
    input  wire logic so,
    input  wire logic soEn
);
    initial begin
        linkClk = 1'b0;
        csN     = 1'b1;
        si      = 1'b0;
    end

    // The link clock only runs inside a frame, as a real controller does.
    task automatic xfer(input logic [55:0] bits, input int nOut, input int nIn,
                        output logic [7:0] rd);
        rd = 8'h00;
        #3 csN = 1'b0;
        for (int i = 0; i < nOut + nIn; i++) begin
            // The data line toggles while unused so that stale values never pass.
            si = (i < nOut) ? bits[55 - i] : ~si;
            #16 linkClk = 1'b1;
            if (i >= nOut + nIn - 8) begin
                rd = {rd[6:0], so & soEn};
            end
            #16 linkClk = 1'b0;
        end
        #16 csN = 1'b1;
        // Idle gap well above the 60 ns the device needs between frames.
        #100;
    endtask
endmodule

// [tb/flash_config_registers_tb.sv]
// Self-checking testbench for the configuration register block.
`timescale 1ns/1ps
`define CHK(nm, e, g) begin n_compared++; if ((g) !== (e)) begin n_fail++; \
    $display("[ERR] %s expected %h seen %h", nm, e, g); end end
module flash_config_registers_tb;
    import fcr_pkg::*;
    logic clk, rst_n, linkClk, csN, si, so, soEn;
    logic eccChunkFail, eccSingleFix, eccDoubleErr, eccDoubleProg, eccUpperHalf;
    logic [2:0] driveStrength;
    logic [4:0] waitCycles;
    logic [7:0] chunkBytes, rd;
    logic [15:0] preamblePattern, preambleLine3;
    logic protectOrigin, preambleEnable, singleRateOctalEn, doubleRateOctalEn;
    logic strobeInSingleRate, strobeLeadCycle, checkPinOutEn, eccFlagPinN;
    int n_fail, n_compared;
    logic [31:0] regAddr [6] = '{ADDR_MODE, ADDR_STROBE, ADDR_WAIT, ADDR_ECC_PIN, ADDR_CHECK,
                                 32'h800};

    fcr_config_regs dut (.*);
    fcr_host_model host (.linkClk(linkClk), .csN(csN), .si(si), .so(so), .soEn(soEn));

    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    // Each write settles 3 clk into the register and 1 more onto the outputs, except mode, which waits for the next frame.
    task automatic wr2(input logic [31:0] a, input logic [7:0] d);
        host.xfer({CMD_WRITE_CFG2, a, d, 8'h00}, 48, 0, rd);
        repeat (8) @(posedge clk);
    endtask
    task automatic rd2(input logic [31:0] a, input logic [7:0] e, input string nm);
        host.xfer({CMD_READ_CFG2, a, 16'h0000}, 40, 16, rd);
        repeat (8) @(posedge clk);
        `CHK(nm, e, rd)
    endtask
    task automatic wrs(input logic [7:0] d, input logic [7:0] e);
        host.xfer({CMD_WRITE_STATUS, 8'h00, d, 32'h0}, 24, 0, rd);
        repeat (8) @(posedge clk);
        host.xfer({CMD_READ_CFG, 48'h0}, 8, 16, rd);
        `CHK("primary", e, rd)
    endtask
    task automatic ev(input logic up, input logic [2:0] k);
        eccChunkFail <= 1'b1;
        {eccDoubleProg, eccDoubleErr, eccSingleFix} <= k;
        eccUpperHalf <= up;
        @(posedge clk);
        eccChunkFail <= 1'b0;
        repeat (3) @(posedge clk);
    endtask
    task give_verdict;
        $display("compared %0d mismatched %0d", n_compared, n_fail);
        if (n_fail == 0 && n_compared > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask

    initial begin
        #400000;
        n_fail++;
        give_verdict();
    end

    initial begin
        {rst_n, eccChunkFail, eccSingleFix, eccDoubleErr, eccDoubleProg, eccUpperHalf} = 6'h00;
        n_fail = 0;
        n_compared = 0;
        repeat (2) @(posedge clk);
        rst_n <= 1'b1;
        repeat (4) @(posedge clk);
        `CHK("drive", 3'h7, driveStrength)
        `CHK("defaults", 6'h00, {protectOrigin, preambleEnable, singleRateOctalEn,
            doubleRateOctalEn, checkPinOutEn, strobeInSingleRate})
        `CHK("wait", 5'h14, waitCycles)
        `CHK("chunk", 8'h10, chunkBytes)
        `CHK("pattern", 32'h349a3514, {preamblePattern, preambleLine3})
        `CHK("flag pin", 1'b1, eccFlagPinN)
        foreach (regAddr[i])
            rd2(regAddr[i], 8'h00, "reset");
        $display("test reset done");
        for (int c = 0; c < 8; c++) begin
            wr2(ADDR_WAIT, 8'hf8 | 8'(c));
            `CHK("wait", 5'(20 - 2 * c), waitCycles)
            rd2(ADDR_WAIT, 8'(c), "wait reg");
        end
        wr2(32'h600, 8'hff);
        rd2(ADDR_WAIT, 8'h07, "unmapped");
        $display("test wait done");
        for (int s = 0; s < 4; s++) begin
            wr2(ADDR_CHECK, 8'h9f | 8'(s << 5));
            `CHK("chunk", 8'(16 << s), chunkBytes)
            `CHK("chk pin", 1'b1, checkPinOutEn)
            `CHK("pattern", 32'h55555555, {preamblePattern, preambleLine3})
            rd2(ADDR_CHECK, 8'h11 | 8'(s << 5), "check reg");
        end
        wr2(ADDR_CHECK, 8'h00);
        `CHK("pattern", 32'h349a3514, {preamblePattern, preambleLine3})
        wr2(ADDR_STROBE, 8'hff);
        `CHK("strobe", 2'h3, {strobeInSingleRate, strobeLeadCycle})
        $display("test check and strobe done");
        wr2(ADDR_MODE, 8'h01);
        `CHK("mode early", 1'b0, singleRateOctalEn)
        rd2(ADDR_MODE, 8'h01, "mode reg");
        `CHK("single", 2'h1, {doubleRateOctalEn, singleRateOctalEn})
        wr2(ADDR_MODE, 8'h03);
        rd2(ADDR_MODE, 8'h01, "inhibit");
        wr2(ADDR_MODE, 8'h02);
        rd2(ADDR_MODE, 8'h02, "mode reg");
        `CHK("double", 2'h2, {doubleRateOctalEn, singleRateOctalEn})
        $display("test mode done");
        wrs(8'hff, 8'h1f);
        `CHK("cfg out", 5'h1f, {preambleEnable, protectOrigin, driveStrength})
        wrs(8'h02, 8'h0a);
        `CHK("cfg out", 5'h0a, {preambleEnable, protectOrigin, driveStrength})
        $display("test primary done");
        for (int c = 0; c < 4; c++) begin
            wr2(ADDR_ECC_PIN, 8'(c));
            for (int k = 0; k < 3; k++) begin
                wr2(32'h800, ECC_CLEAR_DATA);
                ev(1'b0, 3'(1 << k));
                `CHK("flag pin", !(k == 1 || (k == 2 && c < 2) || (k == 0 && c[0])),
                    eccFlagPinN)
                rd2(32'h800, 8'h81 | 8'(16 << k), "ecc stat");
            end
        end
        wr2(32'h800, ECC_CLEAR_DATA);
        repeat (17) ev(1'b0, 3'h1);
        rd2(32'h800, 8'h9f, "saturate");
        repeat (2) ev(1'b1, 3'h2);
        rd2(32'h04000800, 8'ha2, "upper");
        wr2(32'h800, 8'h55);
        rd2(32'h800, 8'h9f, "ro write");
        wr2(32'h04000800, 8'h00);
        rd2(32'h04000800, 8'h00, "upper clr");
        rd2(32'h800, 8'h9f, "lower kept");
        $display("test ecc done");
        give_verdict();
    end
endmodule
